// File: ipwg_pkg.sv
package ipwg_pkg;

  // Register offsets on the serial register port
  localparam logic [7:0] IPWG_ADDR_PIN_CFG  = 8'h7D;
  localparam logic [7:0] IPWG_ADDR_PROT_KEY = 8'h7E;

  // Reset values
  localparam logic [7:0] IPWG_PIN_CFG_RST   = 8'h02;
  localparam logic [7:0] IPWG_PROT_KEY_RST  = 8'h85;

  // Protection key values
  localparam logic [7:0] IPWG_KEY_UNLOCKED  = 8'h85;
  localparam logic [7:0] IPWG_KEY_SINGLE    = 8'h86;
  localparam logic [7:0] IPWG_KEY_RELOCK    = 8'h00;

  // Pin config field positions
  localparam int IPWG_BIT_POLARITY = 0;
  localparam int IPWG_BIT_TRISTATE = 1;
  localparam int IPWG_BIT_STATIC   = 2;
  localparam logic [7:0] IPWG_PIN_CFG_MASK = 8'h07;

  // Protection modes
  typedef enum logic [1:0] {
    IPWG_LOCKED,
    IPWG_OPEN,
    IPWG_ONE_SHOT
  } ipwg_mode_t;

endpackage

// File: ipwg_pin_drv.sv
`timescale 1ns/100ps
module ipwg_pin_drv
  import ipwg_pkg::*;
(
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       rst,
  // Configuration bits
  input  wire logic       pin_as_static_output,
  input  wire logic       tristate_sel,
  input  wire logic       polarity_sel,
  // Interrupt request from the core
  input  wire logic       irq_req,
  // Pin drive
  output logic            irq_pin_o,
  output logic            irq_pin_oe
);

  logic irq_pin_o_r;    // Registered pin level
  logic irq_pin_oe_r;   // Registered pin enable
  logic irq_pin_o_nxt;
  logic irq_pin_oe_nxt;

  // Next pin drive from mode and request
  always_comb
  begin
    if (pin_as_static_output)
    begin
      // Static output: level is the polarity bit, always driven
      irq_pin_o_nxt  = polarity_sel;
      irq_pin_oe_nxt = 1'b1;
    end
    else
    begin
      // Asserted level follows polarity, idle level is its inverse
      irq_pin_o_nxt  = irq_req ? polarity_sel : ~polarity_sel;
      // Shared line: release it while idle so others may drive it
      irq_pin_oe_nxt = tristate_sel ? irq_req : 1'b1;
    end
  end

  // Register the drive so the pin never glitches on decode
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      irq_pin_o_r  <= 1'b1;
      irq_pin_oe_r <= 1'b0;
    end
    else
    begin
      irq_pin_o_r  <= irq_pin_o_nxt;
      irq_pin_oe_r <= irq_pin_oe_nxt;
    end
  end

  assign irq_pin_o  = irq_pin_o_r;
  assign irq_pin_oe = irq_pin_oe_r;

  // Static mode drives the polarity level one cycle later
  a_static_level: assert property (@(posedge clk) disable iff (rst)
    pin_as_static_output |=> (irq_pin_oe && irq_pin_o == $past(polarity_sel)))
    else $error("static output level wrong");

  // Shared mode releases the pin while idle
  a_tristate_idle: assert property (@(posedge clk) disable iff (rst)
    (!pin_as_static_output && tristate_sel && !irq_req) |=> !irq_pin_oe)
    else $error("pin driven while idle in shared mode");

  // Active interrupt shows the polarity level
  a_active_level: assert property (@(posedge clk) disable iff (rst)
    (!pin_as_static_output && irq_req) |=> (irq_pin_oe && irq_pin_o == $past(polarity_sel)))
    else $error("asserted level wrong");

endmodule // ipwg_pin_drv

// File: ipwg_top.sv
`timescale 1ns/100ps
module ipwg_top
  import ipwg_pkg::*;
(
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       rst,
  // Register port from the serial interface
  input  wire logic       reg_wr,
  input  wire logic       reg_rd,
  input  wire logic [7:0] reg_addr,
  input  wire logic [7:0] reg_wdata,
  // Register port answers
  output logic [7:0]      reg_rdata,
  output logic            reg_rvalid,
  output logic            other_wr_accept,
  output logic            other_wr_reject,
  // Interrupt from the core and its pin
  input  wire logic       irq_req,
  output logic            irq_pin_o,
  output logic            irq_pin_oe,
  // Boundary-scan test reset and capture
  input  wire logic       trst_pin_i,
  input  wire logic       trst_pin_driven,
  input  wire logic       bsr_capture,
  input  wire logic       bsr_pin_level,
  output logic            scan_mode,
  output logic            bsr_capture_data
);

  // Register state
  logic [7:0]  pin_cfg_r;          // Interrupt pin configuration
  logic [7:0]  pin_cfg_nxt;
  logic [7:0]  prot_key_r;         // Write protection key
  logic [7:0]  prot_key_nxt;
  logic [7:0]  rdata_r;            // Read answer
  logic [7:0]  rdata_nxt;
  logic        rvalid_r;
  logic        rvalid_nxt;
  logic        accept_r;           // Write to another register let through
  logic        accept_nxt;
  logic        reject_r;           // Write to another register dropped
  logic        reject_nxt;
  logic        scan_mode_r;        // Boundary-scan mode
  logic        scan_mode_nxt;
  logic        capture_r;          // Output cell capture value
  logic        capture_nxt;
  ipwg_mode_t  mode;               // Decoded protection mode

  // Map a key to its protection mode
  function automatic ipwg_mode_t key_mode(input logic [7:0] key);
    if (key == IPWG_KEY_UNLOCKED)
      key_mode = IPWG_OPEN;
    else if (key == IPWG_KEY_SINGLE)
      key_mode = IPWG_ONE_SHOT;
    else
      key_mode = IPWG_LOCKED;
  endfunction

  assign mode = key_mode(prot_key_r);

  // Register writes, protection gate and read mux
  always_comb
  begin
    pin_cfg_nxt  = pin_cfg_r;
    prot_key_nxt = prot_key_r;
    accept_nxt   = 1'b0;
    reject_nxt   = 1'b0;
    rvalid_nxt   = reg_rd;
    rdata_nxt    = 8'h00;
    if (reg_wr)
    begin
      if (reg_addr == IPWG_ADDR_PROT_KEY)
      begin
        // Key is writable in every mode so software never locks itself out
        prot_key_nxt = reg_wdata;
      end
      else if (mode == IPWG_LOCKED)
      begin
        // Locked: the write changes no register and only raises the reject pulse
        reject_nxt = 1'b1;
      end
      else
      begin
        accept_nxt = 1'b1;
        if (reg_addr == IPWG_ADDR_PIN_CFG)
          pin_cfg_nxt = reg_wdata & IPWG_PIN_CFG_MASK;
        // One-shot unlock spends itself on this write
        if (mode == IPWG_ONE_SHOT)
          prot_key_nxt = IPWG_KEY_RELOCK;
      end
    end
    // Unused bits and unmapped offsets read as zero
    if (reg_rd)
    begin
      if (reg_addr == IPWG_ADDR_PIN_CFG)
        rdata_nxt = pin_cfg_r;
      else if (reg_addr == IPWG_ADDR_PROT_KEY)
        rdata_nxt = prot_key_r;
      else
        rdata_nxt = 8'h00;
    end
  end

  // Scan control: an undriven test reset counts as low
  always_comb
  begin
    scan_mode_nxt = trst_pin_driven & trst_pin_i;
    // Output cells capture the pin, never the core, so no internal test
    capture_nxt   = bsr_capture ? bsr_pin_level : capture_r;
  end

  // State registers
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      pin_cfg_r   <= IPWG_PIN_CFG_RST;
      prot_key_r  <= IPWG_PROT_KEY_RST;
      rdata_r     <= 8'h00;
      rvalid_r    <= 1'b0;
      accept_r    <= 1'b0;
      reject_r    <= 1'b0;
      scan_mode_r <= 1'b0;
      capture_r   <= 1'b0;
    end
    else
    begin
      pin_cfg_r   <= pin_cfg_nxt;
      prot_key_r  <= prot_key_nxt;
      rdata_r     <= rdata_nxt;
      rvalid_r    <= rvalid_nxt;
      accept_r    <= accept_nxt;
      reject_r    <= reject_nxt;
      scan_mode_r <= scan_mode_nxt;
      capture_r   <= capture_nxt;
    end
  end

  assign reg_rdata        = rdata_r;
  assign reg_rvalid       = rvalid_r;
  assign other_wr_accept  = accept_r;
  assign other_wr_reject  = reject_r;
  assign scan_mode        = scan_mode_r;
  assign bsr_capture_data = capture_r;

  // Interrupt pin driver
  ipwg_pin_drv u_pin_drv (
    .clk                  (clk),
    .rst                  (rst),
    .pin_as_static_output (pin_cfg_r[IPWG_BIT_STATIC]),
    .tristate_sel         (pin_cfg_r[IPWG_BIT_TRISTATE]),
    .polarity_sel         (pin_cfg_r[IPWG_BIT_POLARITY]),
    .irq_req              (irq_req),
    .irq_pin_o            (irq_pin_o),
    .irq_pin_oe           (irq_pin_oe)
  );

  // Sequences for the one-shot unlock
  sequence s_other_write;
    reg_wr && reg_addr != IPWG_ADDR_PROT_KEY;
  endsequence

  sequence s_one_shot_write;
    (mode == IPWG_ONE_SHOT) ##0 s_other_write;
  endsequence

  a_pin_cfg_store: assert property (@(posedge clk) disable iff (rst)
    (mode != IPWG_LOCKED && reg_wr && reg_addr == IPWG_ADDR_PIN_CFG)
      |=> pin_cfg_r == ($past(reg_wdata) & IPWG_PIN_CFG_MASK))
    else $error("pin config write lost");

  a_locked_hold: assert property (@(posedge clk) disable iff (rst)
    (mode == IPWG_LOCKED) ##0 s_other_write |=> ($stable(pin_cfg_r) && reject_r && !accept_r))
    else $error("write passed while locked");

  a_open_stays: assert property (@(posedge clk) disable iff (rst)
    (mode == IPWG_OPEN) ##0 s_other_write |=> (accept_r && mode == IPWG_OPEN))
    else $error("open mode changed by ordinary write");

  a_one_shot_relock: assert property (@(posedge clk) disable iff (rst)
    s_one_shot_write |=> (accept_r && prot_key_r == IPWG_KEY_RELOCK))
    else $error("one-shot unlock did not relock");

  a_key_writable: assert property (@(posedge clk) disable iff (rst)
    (reg_wr && reg_addr == IPWG_ADDR_PROT_KEY) |=> prot_key_r == $past(reg_wdata))
    else $error("key write refused");

  a_scan_default: assert property (@(posedge clk) disable iff (rst)
    !trst_pin_driven |=> !scan_mode)
    else $error("scan mode without driven test reset");

  a_capture_pin: assert property (@(posedge clk) disable iff (rst)
    bsr_capture |=> bsr_capture_data == $past(bsr_pin_level))
    else $error("capture not from pin");

  // Without a strobe the cell keeps its last captured level
  a_capture_hold: assert property (@(posedge clk) disable iff (rst)
    !bsr_capture |=> $stable(bsr_capture_data))
    else $error("capture changed without strobe");

  // A driven-high test reset must enter scan mode
  a_scan_enable: assert property (@(posedge clk) disable iff (rst)
    (trst_pin_driven && trst_pin_i) |=> scan_mode)
    else $error("scan mode not entered");

  // Back-to-back writes: only the first one passes a one-shot unlock
  a_one_shot_spent: assert property (@(posedge clk) disable iff (rst)
    s_one_shot_write ##1 s_other_write |=> (reject_r && !accept_r && $stable(pin_cfg_r)))
    else $error("second write passed one-shot unlock");

  // Key writes are not gated, so they raise neither pulse
  a_key_no_pulse: assert property (@(posedge clk) disable iff (rst)
    (reg_wr && reg_addr == IPWG_ADDR_PROT_KEY) |=> (!accept_r && !reject_r))
    else $error("key write reported as gated");

  // Unused configuration bits never hold a one
  a_unused_zero: assert property (@(posedge clk) disable iff (rst)
    pin_cfg_r[7:3] == 5'h00)
    else $error("unused config bits set");

  // A read answers with the value held before the read edge
  a_read_answer: assert property (@(posedge clk) disable iff (rst)
    (reg_rd && reg_addr == IPWG_ADDR_PIN_CFG) |=> (reg_rvalid && reg_rdata == $past(pin_cfg_r)))
    else $error("config read answer wrong");

endmodule // ipwg_top

// File: ipwg_host.sv
`timescale 1ns/100ps
// Host processor model: drives the register port, sees a shared interrupt line
module ipwg_host
  import ipwg_pkg::*;
(
  // Clock
  input  wire logic       clk,
  // Register port
  output logic            reg_wr,
  output logic            reg_rd,
  output logic [7:0]      reg_addr,
  output logic [7:0]      reg_wdata,
  // Interrupt pin and the resolved board line
  input  wire logic       irq_pin_o,
  input  wire logic       irq_pin_oe,
  output logic            irq_line
);
  // Board pull-up: a released line reads high, never the last driven level
  assign irq_line = irq_pin_oe ? irq_pin_o : 1'b1;

  // Idle port at time zero
  initial
  begin
    reg_wr    = 1'b0;
    reg_rd    = 1'b0;
    reg_addr  = 8'h00;
    reg_wdata = 8'h00;
  end

  // One access; request held for exactly the edge that takes it
  task automatic access(input logic wr, input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_wr    <= wr;
    reg_rd    <= ~wr;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr    <= 1'b0;
    reg_rd    <= 1'b0;
    // Answer stands one cycle; caller samples it now
    #1;
  endtask

  // Two writes on consecutive edges; the port takes them back to back
  task automatic write2(input logic [7:0] a, input logic [7:0] d0, input logic [7:0] d1);
    @(posedge clk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d0;
    @(posedge clk);
    reg_wdata <= d1;
    @(posedge clk);
    reg_wr    <= 1'b0;
    #1;
  endtask

  // Software writes the key before touching other registers
  task automatic set_key(input logic [7:0] k);
    access(1'b1, IPWG_ADDR_PROT_KEY, k);
  endtask
endmodule // ipwg_host

// File: ipwg_top_test.sv
`timescale 1ns/100ps
module ipwg_top_test;
  import ipwg_pkg::*;
  // Bench signals
  logic clk = 1'b0, rst = 1'b1, irq_req = 1'b0;
  logic trst_i = 1'b0, trst_drv = 1'b0, cap = 1'b0, pin_lvl = 1'b0;
  wire logic wr, rd, oe, po, line, scan, capd, rv, acc, rej;
  wire logic [7:0] addr, wdata, rdata;
  int err_count = 0, samples_checked = 0, cyc = 0;

  ipwg_host host (.clk(clk), .reg_wr(wr), .reg_rd(rd), .reg_addr(addr), .reg_wdata(wdata),
    .irq_pin_o(po), .irq_pin_oe(oe), .irq_line(line));
  ipwg_top dut (.clk(clk), .rst(rst), .reg_wr(wr), .reg_rd(rd), .reg_addr(addr),
    .reg_wdata(wdata), .reg_rdata(rdata), .reg_rvalid(rv), .other_wr_accept(acc),
    .other_wr_reject(rej), .irq_req(irq_req), .irq_pin_o(po), .irq_pin_oe(oe),
    .trst_pin_i(trst_i), .trst_pin_driven(trst_drv), .bsr_capture(cap),
    .bsr_pin_level(pin_lvl), .scan_mode(scan), .bsr_capture_data(capd));

  // 125 MHz clock
  always #4 clk = ~clk;

  // Hang guard, well above the fewer than two hundred cycles the tests need
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 3000)
    begin
      err_count++;
      conclude();
    end
  end

  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    samples_checked++;
    if (g !== e)
    begin
      err_count++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask

  // Read one register and compare data and valid
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
    host.access(1'b0, a, 8'h00);
    chk("rvalid", 8'h01, {7'h00, rv});
    chk("rdata", e, rdata);
  endtask

  // Write a non-key register; see which pulse comes back
  task automatic wr_chk(input logic [7:0] d, input logic ok);
    host.access(1'b1, IPWG_ADDR_PIN_CFG, d);
    chk("accept", {7'h00, ok}, {7'h00, acc});
    chk("reject", {7'h00, ~ok}, {7'h00, rej});
  endtask

  task automatic t_reset();
    chk("line idle", 8'h01, {7'h00, line});
    rd_chk(IPWG_ADDR_PIN_CFG, IPWG_PIN_CFG_RST);
    rd_chk(IPWG_ADDR_PROT_KEY, IPWG_PROT_KEY_RST);
    $display("reset test done");
  endtask

  // Every pin mode with the request idle and active
  task automatic t_pins();
    logic e_oe, e_o;
    for (int c = 0; c < 8; c++)
    begin
      wr_chk({5'h1F, c[2:0]}, 1'b1);
      rd_chk(IPWG_ADDR_PIN_CFG, {5'h00, c[2:0]});
      for (int q = 0; q < 2; q++)
      begin
        @(posedge clk);
        irq_req <= q[0];
        repeat (2) @(posedge clk);
        #1;
        // Static output ignores the request and the tri-state bit
        e_oe = c[2] | ~c[1] | q[0];
        e_o  = c[2] ? c[0] : (q[0] ? c[0] : ~c[0]);
        chk("pin oe", {7'h00, e_oe}, {7'h00, oe});
        chk("pin line", {7'h00, e_oe ? e_o : 1'b1}, {7'h00, line});
      end
    end
    $display("pin test done");
  endtask

  // Protection boundaries, one-shot relock, full unlock
  task automatic t_protect();
    logic [7:0] keys [4] = '{8'h00, 8'h84, 8'h87, 8'hFF};
    foreach (keys[i])
    begin
      host.set_key(keys[i]);
      rd_chk(IPWG_ADDR_PROT_KEY, keys[i]);
      wr_chk(8'h00, 1'b0);
      rd_chk(IPWG_ADDR_PIN_CFG, 8'h07);
    end
    host.set_key(IPWG_KEY_SINGLE);
    wr_chk(8'h01, 1'b1);
    rd_chk(IPWG_ADDR_PROT_KEY, IPWG_KEY_RELOCK);
    wr_chk(8'h03, 1'b0);
    rd_chk(IPWG_ADDR_PIN_CFG, 8'h01);
    host.set_key(IPWG_KEY_UNLOCKED);
    wr_chk(8'h04, 1'b1);
    wr_chk(8'h02, 1'b1);
    host.set_key(IPWG_KEY_SINGLE);
    host.write2(IPWG_ADDR_PIN_CFG, 8'h05, 8'h06);
    chk("reject", 8'h01, {7'h00, rej});
    rd_chk(IPWG_ADDR_PIN_CFG, 8'h05);
    $display("protection test done");
  endtask

  // Test-reset pull-down and pin-only capture
  task automatic t_scan();
    for (int k = 0; k < 4; k++)
    begin
      @(posedge clk);
      trst_drv <= k[1];
      trst_i   <= k[0];
      repeat (2) @(posedge clk);
      #1;
      chk("scan mode", {7'h00, k[1] & k[0]}, {7'h00, scan});
    end
    for (int v = 0; v < 2; v++)
    begin
      @(posedge clk);
      pin_lvl <= v[0];
      irq_req <= ~v[0];
      cap     <= 1'b1;
      @(posedge clk);
      cap     <= 1'b0;
      #1;
      chk("capture", {7'h00, v[0]}, {7'h00, capd});
    end
    $display("scan test done");
  endtask

  task automatic conclude();
    $display("checks %0d mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  // Main sequence
  initial
  begin
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    t_reset();
    t_pins();
    t_protect();
    t_scan();
    conclude();
  end
endmodule // ipwg_top_test
